/* File: src/unb_port.sv */
// Nine-bit asynchronous serial port with an AXI4-Lite register slave.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "unb_regs.svh"
module unb_port
  import unb_pkg::*;
(
  // Clock and reset.
  input  wire logic                   SYS_CLK,
  input  wire logic                   RSTN,
  // AXI4-Lite write address and data.
  input  wire logic [`UNB_ADDR_W-1:0] AWADDR,
  input  wire logic                   AWVALID,
  output logic                        AWREADY,
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  input  wire logic                   WVALID,
  output logic                        WREADY,
  // AXI4-Lite write response.
  output logic [1:0]                  BRESP,
  output logic                        BVALID,
  input  wire logic                   BREADY,
  // AXI4-Lite read.
  input  wire logic [`UNB_ADDR_W-1:0] ARADDR,
  input  wire logic                   ARVALID,
  output logic                        ARREADY,
  output logic [31:0]                 RDATA,
  output logic [1:0]                  RRESP,
  output logic                        RVALID,
  input  wire logic                   RREADY,
  // Serial lines.
  output logic                        TX,
  input  wire logic                   RX,
  // Timer overflow pulses for the variable rate.
  input  wire logic                   TIMER1_OVF,
  input  wire logic                   TIMER2_OVF,
  // Interrupt.
  output logic                        IRQ
);

  unb_tx_if tif ();

  logic [9:0]             ctrl_r;
  logic [7:0]             rxbuf_r;
  logic [2:0]             irq_stat_r;
  logic [2:0]             irq_mask_r;
  logic                   aw_hold_r;
  logic                   w_hold_r;
  logic [`UNB_ADDR_W-1:0] awaddr_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   bvalid_r;
  logic [1:0]             bresp_r;
  logic                   rvalid_r;
  logic [31:0]            rdata_r;
  logic [1:0]             rresp_r;
  logic                   wr_go;
  logic                   prediv_r;
  logic                   tx_tick;
  logic                   rx_tick;
  unb_rx_state_e          rx_state_r;
  unb_shift_t             rx_sr_r;
  logic [3:0]             rx_cnt_r;
  logic                   rx_prev_r;
  logic [2:0]             votes_r;
  logic                   rx_bit;
  logic                   rx_roll;
  logic                   rx_load;
  logic                   rx_drop;
  logic                   ctrl_wr;
  logic                   rx_done_clr;
  logic                   tx_done_clr;

  // Sample tick source: prescaled oscillator, or the chosen timer overflow.
  function automatic logic pick_tick(input logic var_rate, input logic use_t2,
                                     input logic fixed_tick, input logic t1,
                                     input logic t2);
    begin
      if (var_rate)
        pick_tick = use_t2 ? t2 : t1;
      else
        pick_tick = fixed_tick;
    end
  endfunction : pick_tick

  // Two of three majority vote of the mid-bit samples.
  function automatic logic vote(input logic [2:0] s);
    begin
      vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction : vote

  // Halving prescaler; a tick every clock gives 1/16, every other clock 1/32.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      prediv_r <= 1'b0;
    else
      prediv_r <= ~prediv_r;
  end

  assign tx_tick = pick_tick(ctrl_r[`UNB_CTRL_VAR_RATE], ctrl_r[`UNB_CTRL_TX_T2],
                             ~ctrl_r[`UNB_CTRL_DIV32] | prediv_r, TIMER1_OVF, TIMER2_OVF);
  assign rx_tick = pick_tick(ctrl_r[`UNB_CTRL_VAR_RATE], ctrl_r[`UNB_CTRL_RX_T2],
                             ~ctrl_r[`UNB_CTRL_DIV32] | prediv_r, TIMER1_OVF, TIMER2_OVF);

  // Write address and data are caught independently, in either order.
  assign AWREADY = !aw_hold_r && !bvalid_r;
  assign WREADY  = !w_hold_r && !bvalid_r;
  assign wr_go   = aw_hold_r && w_hold_r && !bvalid_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= {`UNB_ADDR_W{1'b0}};
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= AWADDR;
      end
      else if (wr_go)
        aw_hold_r <= 1'b0;
      if (WVALID && WREADY)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
      end
      else if (wr_go)
        w_hold_r <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `UNB_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      if (awaddr_r == `UNB_OFS_CTRL || awaddr_r == `UNB_OFS_DATA ||
          awaddr_r == `UNB_OFS_IRQ_STAT || awaddr_r == `UNB_OFS_IRQ_MASK)
        bresp_r <= `UNB_RESP_OKAY;
      else
        bresp_r <= `UNB_RESP_SLVERR;
    end
    else if (BREADY)
      bvalid_r <= 1'b0;
  end

  assign BVALID = bvalid_r;
  assign BRESP  = bresp_r;

  // Buffer write starts a frame; only byte lane 0 carries the data.
  assign tif.load  = wr_go && (awaddr_r == `UNB_OFS_DATA) && wstrb_r[0];
  assign tif.data  = wdata_r[7:0];
  assign tif.ninth = ctrl_r[`UNB_CTRL_TX_NINTH];
  assign tif.tick  = tx_tick;
  assign TX        = tif.line;

  unb_tx u_tx (
    .SYS_CLK (SYS_CLK),
    .RSTN    (RSTN),
    .tif     (tif.tx)
  );

  // Writing zero clears a done flag; writing one leaves it alone.
  assign ctrl_wr     = wr_go && (awaddr_r == `UNB_OFS_CTRL);
  assign rx_done_clr = ctrl_wr && wstrb_r[0] && !wdata_r[`UNB_CTRL_RX_DONE];
  assign tx_done_clr = ctrl_wr && wstrb_r[0] && !wdata_r[`UNB_CTRL_TX_DONE];

  // Control register; hardware sets of the done flags win over a clearing write.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      ctrl_r <= `UNB_CTRL_RST;
    else
    begin
      if (ctrl_wr && wstrb_r[0])
      begin
        ctrl_r[`UNB_CTRL_TX_NINTH] <= wdata_r[`UNB_CTRL_TX_NINTH];
        ctrl_r[`UNB_CTRL_MP_FILT]  <= wdata_r[`UNB_CTRL_MP_FILT];
        ctrl_r[`UNB_CTRL_VAR_RATE] <= wdata_r[`UNB_CTRL_VAR_RATE];
        ctrl_r[`UNB_CTRL_DIV32]    <= wdata_r[`UNB_CTRL_DIV32];
      end
      if (ctrl_wr && wstrb_r[1])
      begin
        ctrl_r[`UNB_CTRL_TX_T2] <= wdata_r[`UNB_CTRL_TX_T2];
        ctrl_r[`UNB_CTRL_RX_T2] <= wdata_r[`UNB_CTRL_RX_T2];
      end
      if (rx_load)
      begin
        ctrl_r[`UNB_CTRL_RX_DONE]  <= 1'b1;
        ctrl_r[`UNB_CTRL_RX_NINTH] <= rx_bit;
      end
      else if (rx_done_clr)
        ctrl_r[`UNB_CTRL_RX_DONE] <= 1'b0;
      if (tif.done)
        ctrl_r[`UNB_CTRL_TX_DONE] <= 1'b1;
      else if (tx_done_clr)
        ctrl_r[`UNB_CTRL_TX_DONE] <= 1'b0;
    end
  end

  // Interrupt status is write-one-to-clear, mask is plain read and write.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      irq_stat_r <= `UNB_IRQ_RST;
      irq_mask_r <= `UNB_IRQ_RST;
    end
    else
    begin
      if (wr_go && awaddr_r == `UNB_OFS_IRQ_MASK && wstrb_r[0])
        irq_mask_r <= wdata_r[2:0];
      if (wr_go && awaddr_r == `UNB_OFS_IRQ_STAT && wstrb_r[0])
        irq_stat_r <= (irq_stat_r & ~wdata_r[2:0]) | {rx_drop, tif.done, rx_load};
      else
        irq_stat_r <= irq_stat_r | {rx_drop, tif.done, rx_load};
    end
  end

  assign IRQ = |(irq_stat_r & irq_mask_r);

  // Register reads; one read in flight, unmapped addresses give a slave error.
  assign ARREADY = !rvalid_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `UNB_RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= `UNB_RESP_OKAY;
      if (ARADDR == `UNB_OFS_CTRL)
        rdata_r <= {22'h0, ctrl_r};
      else if (ARADDR == `UNB_OFS_DATA)
        rdata_r <= {24'h000000, rxbuf_r};
      else if (ARADDR == `UNB_OFS_IRQ_STAT)
        rdata_r <= {29'h0, irq_stat_r};
      else if (ARADDR == `UNB_OFS_IRQ_MASK)
        rdata_r <= {29'h0, irq_mask_r};
      else
      begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= `UNB_RESP_SLVERR;
      end
    end
    else if (RREADY)
      rvalid_r <= 1'b0;
  end

  assign RVALID = rvalid_r;
  assign RDATA  = rdata_r;
  assign RRESP  = rresp_r;

  // Receive bit decision and frame-end conditions.
  assign rx_bit  = vote(votes_r);
  assign rx_roll = rx_tick && (rx_cnt_r == `UNB_CNT_LAST);
  // The stop bit is never looked at; the decision is taken at the ninth-bit shift.
  assign rx_load = (rx_state_r == UNB_RX_BITS) && rx_roll && !rx_sr_r[0]
                   && !ctrl_r[`UNB_CTRL_RX_DONE]
                   && (!ctrl_r[`UNB_CTRL_MP_FILT] || rx_bit);
  assign rx_drop = (rx_state_r == UNB_RX_BITS) && rx_roll && !rx_sr_r[0] && !rx_load;

  // Receive sequencer: hunt for an edge, vote each bit, shift, then skip the stop bit.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      rx_state_r <= UNB_RX_HUNT;
      rx_sr_r    <= `UNB_RX_SR_FILL;
      rx_cnt_r   <= 4'h0;
      rx_prev_r  <= 1'b1;
      votes_r    <= 3'h7;
    end
    else if (rx_tick)
    begin
      rx_prev_r <= RX;
      rx_cnt_r  <= rx_cnt_r + 4'h1;
      if (rx_cnt_r == `UNB_SAMPLE_A)
        votes_r[0] <= RX;
      if (rx_cnt_r == `UNB_SAMPLE_B)
        votes_r[1] <= RX;
      if (rx_cnt_r == `UNB_SAMPLE_C)
        votes_r[2] <= RX;
      case (rx_state_r)
        UNB_RX_HUNT:
        begin
          if (rx_prev_r && !RX)
          begin
            rx_cnt_r   <= 4'h0;
            rx_sr_r    <= `UNB_RX_SR_FILL;
            rx_state_r <= UNB_RX_BITS;
          end
        end
        UNB_RX_BITS:
        begin
          if (rx_roll)
          begin
            if (rx_sr_r == `UNB_RX_SR_FILL && rx_bit)
              rx_state_r <= UNB_RX_HUNT;
            else
            begin
              rx_sr_r <= {rx_bit, rx_sr_r[8:1]};
              if (!rx_sr_r[0])
                rx_state_r <= UNB_RX_STOP;
            end
          end
        end
        UNB_RX_STOP:
        begin
          // Holding off one bit keeps the stop bit's own edges from retriggering.
          if (rx_roll)
            rx_state_r <= UNB_RX_HUNT;
        end
        default:
          rx_state_r <= UNB_RX_HUNT;
      endcase
    end
  end

  // Receive buffer takes the eight data bits of an accepted frame.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      rxbuf_r <= `UNB_RXBUF_RST;
    else if (rx_load)
      rxbuf_r <= rx_sr_r[8:1];
  end

endmodule : unb_port

/* File: src/unb_regs.svh */
// Register offsets, field positions, reset values and timing counts of the nine-bit serial port.
`ifndef UNB_REGS_SVH
`define UNB_REGS_SVH

`define UNB_ADDR_W          4
`define UNB_OFS_CTRL        4'h0
`define UNB_OFS_DATA        4'h4
`define UNB_OFS_IRQ_STAT    4'h8
`define UNB_OFS_IRQ_MASK    4'hc

`define UNB_CTRL_RX_DONE    0
`define UNB_CTRL_TX_DONE    1
`define UNB_CTRL_RX_NINTH   2
`define UNB_CTRL_TX_NINTH   3
`define UNB_CTRL_MP_FILT    4
`define UNB_CTRL_VAR_RATE   5
`define UNB_CTRL_DIV32      6
`define UNB_CTRL_TX_T2      8
`define UNB_CTRL_RX_T2      9

`define UNB_IRQ_RX          0
`define UNB_IRQ_TX          1
`define UNB_IRQ_DROP        2

`define UNB_CTRL_RST        10'h000
`define UNB_IRQ_RST         3'h0
`define UNB_RXBUF_RST       8'h00

`define UNB_CNT_LAST        4'hf
`define UNB_SAMPLE_A        4'h7
`define UNB_SAMPLE_B        4'h8
`define UNB_SAMPLE_C        4'h9
`define UNB_RX_SR_FILL      9'h1ff
`define UNB_TX_LAST_PAT     9'h003

`define UNB_RESP_OKAY       2'b00
`define UNB_RESP_SLVERR     2'b10

`endif

/* File: src/unb_pkg.sv */
// Types shared by the nine-bit serial port modules.
package unb_pkg;

  typedef enum logic [2:0] {
    UNB_TX_IDLE  = 3'b001,
    UNB_TX_START = 3'b010,
    UNB_TX_SHIFT = 3'b100
  } unb_tx_state_e;

  typedef enum logic [2:0] {
    UNB_RX_HUNT = 3'b001,
    UNB_RX_BITS = 3'b010,
    UNB_RX_STOP = 3'b100
  } unb_rx_state_e;

  typedef logic [8:0] unb_shift_t;

endpackage : unb_pkg

/* File: src/unb_tx_if.sv */
// Connection between the port top and its transmitter.
`timescale 1ns/1ps
interface unb_tx_if;
  logic       load;
  logic [7:0] data;
  logic       ninth;
  logic       tick;
  logic       line;
  logic       done;

  modport ctl (output load, output data, output ninth, output tick, input line, input done);
  modport tx  (input load, input data, input ninth, input tick, output line, output done);
endinterface : unb_tx_if

/* File: src/unb_tx.sv */
// Transmitter of the nine-bit frame: start, eight data bits, ninth bit, stop.
`timescale 1ns/1ps
`include "unb_regs.svh"
module unb_tx
  import unb_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Link to the port top.
  unb_tx_if.tx     tif
);

  unb_tx_state_e state_r;
  unb_shift_t    sr_r;
  logic [3:0]    cnt_r;
  logic          req_r;
  logic          first_r;
  logic          done_r;
  logic          roll;

  // A bit boundary is a rollover of the divide-by-16 counter, not the buffer write.
  assign roll = tif.tick && (cnt_r == `UNB_CNT_LAST);

  // Divide-by-16 counter free-runs so the start edge is always on a boundary.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      cnt_r <= 4'h0;
    else if (tif.tick)
      cnt_r <= cnt_r + 4'h1;
  end

  // Request, shift register and sequencing of the frame.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      state_r <= UNB_TX_IDLE;
      sr_r    <= 9'h000;
      req_r   <= 1'b0;
      first_r <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (tif.load)
      begin
        // A write mid-frame restarts the frame; software should wait for done.
        sr_r    <= {tif.ninth, tif.data};
        req_r   <= 1'b1;
        first_r <= 1'b1;
        state_r <= UNB_TX_IDLE;
      end
      else if (roll)
      begin
        case (state_r)
          UNB_TX_IDLE:
          begin
            if (req_r)
            begin
              req_r   <= 1'b0;
              state_r <= UNB_TX_START;
            end
          end
          UNB_TX_START:
            state_r <= UNB_TX_SHIFT;
          UNB_TX_SHIFT:
          begin
            // Stop bit is inserted on the first shift, zeros afterwards.
            sr_r    <= {first_r, sr_r[8:1]};
            first_r <= 1'b0;
            // The ninth bit may be either value, so bit 0 is masked; the raw load is skipped.
            if (!first_r && ((sr_r | 9'h001) == `UNB_TX_LAST_PAT))
            begin
              state_r <= UNB_TX_IDLE;
              done_r  <= 1'b1;
            end
          end
          default:
            state_r <= UNB_TX_IDLE;
        endcase
      end
    end
  end

  // Line: start bit while starting, shift output while shifting, idle high otherwise.
  assign tif.line = (state_r == UNB_TX_START) ? 1'b0 :
                    (state_r == UNB_TX_SHIFT) ? sr_r[0] : 1'b1;
  assign tif.done = done_r;

endmodule : unb_tx

/* File: tb/unb_port_assertions.sv */
// Port checks for the nine-bit serial port, bound to its top.
`timescale 1ns/1ps
`include "unb_regs.svh"
module unb_port_assertions (
  // Clock and reset.
  input wire logic                   SYS_CLK,
  input wire logic                   RSTN,
  // Register bus.
  input wire logic [`UNB_ADDR_W-1:0] AWADDR,
  input wire logic                   AWVALID,
  input wire logic                   AWREADY,
  input wire logic                   WVALID,
  input wire logic                   WREADY,
  input wire logic [1:0]             BRESP,
  input wire logic                   BVALID,
  input wire logic                   BREADY,
  input wire logic                   ARVALID,
  input wire logic                   ARREADY,
  input wire logic [31:0]            RDATA,
  input wire logic                   RVALID,
  input wire logic                   RREADY,
  // Line and interrupt.
  input wire logic                   TX,
  input wire logic                   IRQ
);
  default clocking dc @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  // Address of the last write taken, so its response code can be judged.
  logic [`UNB_ADDR_W-1:0] aw_r;
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      aw_r <= '0;
    else if (AWVALID && AWREADY)
      aw_r <= AWADDR;
  end

  // No level on the line is shorter than one bit at the fastest rate.
  sequence s_low_bit;
    !TX [*8] ##1 !TX [*8];
  endsequence
  sequence s_high_bit;
    TX [*8] ##1 TX [*8];
  endsequence
  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence

  a_reset_quiet: assert property ($rose(RSTN) |-> TX && !IRQ && !BVALID && !RVALID)
    else $error("outputs not idle after reset");
  a_low_bit: assert property ($fell(TX) |-> s_low_bit)
    else $error("low level shorter than one bit");
  a_high_bit: assert property ($rose(TX) |-> s_high_bit)
    else $error("high level shorter than one bit");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] BVALID)
    else $error("write response missing");
  a_bresp_code: assert property ($rose(BVALID) |->
    BRESP == ((aw_r[1:0] == 2'b00) ? `UNB_RESP_OKAY : `UNB_RESP_SLVERR))
    else $error("wrong write response code");
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  a_busy_refuse: assert property ((BVALID |-> !AWREADY && !WREADY) and (RVALID |-> !ARREADY))
    else $error("request taken while answer pending");
endmodule : unb_port_assertions

bind unb_port unb_port_assertions u_chk (.SYS_CLK, .RSTN, .AWADDR, .AWVALID, .AWREADY, .WVALID,
  .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY, .TX, .IRQ);

/* File: tb/unb_far_end.sv */
// Far-end serial device: sends frames on the receive line, catches frames from the transmit line.
`timescale 1ns/1ps
module unb_far_end (
  // Clock.
  input wire logic clk,
  // Serial lines seen from the far end.
  input wire logic line_in,
  output logic     line_out
);
  int          bit_clk = 16;  // Clocks per bit sent.
  int          cap_clk = 16;  // Clocks per bit caught.
  logic [10:0] cap_q[$];      // Caught frames, start bit in bit 0.

  // The line idles high between frames.
  initial
  begin
    line_out = 1'b1;
  end

  // Catch a frame from its start edge, sampling each bit in its middle.
  always
  begin : catch_frame
    logic [10:0] f;
    @(posedge clk iff line_in === 1'b0);
    repeat (cap_clk / 2) @(posedge clk);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = line_in;
      repeat ((i < 10) ? cap_clk : 0) @(posedge clk);
    end
    cap_q.push_back(f);
  end

  // Send one frame; a glitch flips one clock inside each data bit and the ninth bit.
  task automatic send(input logic [7:0] d, input logic n9, input logic glitch, input logic stop);
    logic [10:0] f;
    f = {stop, n9, d, 1'b0};
    for (int i = 0; i < 11; i++)
      for (int c = 0; c < bit_clk; c++)
      begin
        @(posedge clk);
        line_out <= f[i] ^ (glitch && c == 9 && i > 0 && i < 10);
      end
    @(posedge clk);
    line_out <= 1'b1;
  endtask : send

  // A low pulse too short to pass as a start bit.
  task automatic false_start();
    @(posedge clk);
    line_out <= 1'b0;
    repeat (4) @(posedge clk);
    line_out <= 1'b1;
    repeat (4 * bit_clk) @(posedge clk);
  endtask : false_start
endmodule : unb_far_end

/* File: tb/testbench.sv */
// Self-checking bench for the nine-bit serial port.
`timescale 1ns/1ps
module testbench;
  // Bench drives.
  logic        clk = 1'b0, rstn = 1'b0, t1 = 1'b0, t2 = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  // Design and far-end drives.
  logic        awready, wready, bvalid, arready, rvalid, tx, rx, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          errors = 0, samples_checked = 0, cyc = 0;

  typedef struct {logic [7:0] d; logic n9; logic filt; logic [31:0] rate; int tc; int rc;} unb_row_s;
  unb_row_s rows[4] = '{'{8'ha5, 1'b0, 1'b0, 32'h000, 16, 16}, '{8'h3c, 1'b1, 1'b0, 32'h040, 32, 32},
                        '{8'h5a, 1'b0, 1'b1, 32'h220, 32, 16}, '{8'hc3, 1'b1, 1'b1, 32'h120, 16, 32}};

  unb_port dut (.SYS_CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .TX(tx), .RX(rx), .TIMER1_OVF(t1),
    .TIMER2_OVF(t2), .IRQ(irq));
  unb_far_end far (.clk(clk), .line_in(tx), .line_out(rx));

  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bus state is judged at the falling edge, so nothing races the design's flops.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok)
    begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok  = wvalid && wready;
      b_ok  = bvalid && bready;
      if (b_ok)
        chk(32'(bresp), 32'(er));
      @(posedge clk);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
      if (b_ok)
        bready <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_ok, r_ok;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok)
    begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_ok  = rvalid && rready;
      if (r_ok)
      begin
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
      end
      @(posedge clk);
      if (ar_ok)
        arvalid <= 1'b0;
      if (r_ok)
        rready <= 1'b0;
    end
  endtask : rd

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // Timer 1 ticks every other clock, timer 2 every clock; the cycle count guards against hangs.
  always @(posedge clk)
  begin
    t1  <= ~t1;
    t2  <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      give_verdict();
    end
  end

  initial
  begin : main
    logic [31:0] cfg, buf_e;
    logic        acc, rx9;
    int          n, t0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    buf_e = '0;
    rx9   = 1'b0;
    // Each row: one frame out, one frame back, at its own rate and filter setting.
    foreach (rows[i])
    begin
      cfg = rows[i].rate | {27'h0, rows[i].filt, rows[i].n9, 3'h0};
      acc = !rows[i].filt || rows[i].n9;
      far.cap_clk = rows[i].tc;
      far.bit_clk = rows[i].rc;
      wr(4'h0, cfg, 2'b00);
      wr(4'h4, {24'h0, rows[i].d}, 2'b00);
      wait (far.cap_q.size() != 0);
      chk(32'(far.cap_q.pop_front()), 32'({1'b1, rows[i].n9, rows[i].d, 1'b0}));
      far.send(~rows[i].d, rows[i].n9, 1'b0, 1'b1);
      if (acc)
      begin
        buf_e = {24'h0, ~rows[i].d};
        rx9   = rows[i].n9;
      end
      rd(4'h0, cfg | {29'h0, rx9, 1'b1, acc}, 2'b00);
      rd(4'h4, buf_e, 2'b00);
      rd(4'h8, {29'h0, !acc, 1'b1, acc}, 2'b00);
      wr(4'h8, 32'h7, 2'b00);
    end
    // Unmapped places answer with an error.
    wr(4'h6, 32'h1, 2'b10);
    rd(4'h2, 32'h0, 2'b10);
    // A frame arriving while the last is unread is dropped; the drop raises the interrupt.
    wr(4'hc, 32'h4, 2'b00);
    far.send(8'h11, 1'b1, 1'b0, 1'b1);
    rd(4'h4, buf_e, 2'b00);
    rd(4'h8, 32'h4, 2'b00);
    rd(4'h0, cfg | 32'h7, 2'b00);
    chk(32'(irq), 32'h1);
    wr(4'hc, 32'h0, 2'b00);
    chk(32'(irq), 32'h0);
    wr(4'hc, 32'h4, 2'b00);
    chk(32'(irq), 32'h1);
    wr(4'h8, 32'h4, 2'b00);
    chk(32'(irq), 32'h0);
    // False start, a noisy frame with a low stop bit, then a frame close behind it.
    wr(4'h0, 32'h0, 2'b00);
    far.bit_clk = 16;
    far.cap_clk = 16;
    far.false_start();
    far.send(8'h96, 1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    far.send(8'h69, 1'b1, 1'b0, 1'b1);
    rd(4'h4, 32'h96, 2'b00);
    rd(4'h0, 32'h1, 2'b00);
    rd(4'h8, 32'h5, 2'b00);
    // Start waits for the next rollover; done comes eleven rollovers after the write.
    wr(4'h0, 32'h0, 2'b00);
    wr(4'h8, 32'h7, 2'b00);
    wr(4'hc, 32'h2, 2'b00);
    wr(4'h4, 32'h1, 2'b00);
    n  = 0;
    t0 = 999;
    while (irq !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (tx === 1'b0 && t0 == 999)
        t0 = n;
    end
    chk(32'(t0 <= 17), 32'h1);
    chk(32'(n >= 155 && n <= 178), 32'h1);
    wait (far.cap_q.size() != 0);
    chk(32'(far.cap_q.pop_front()), 32'h402);
    // A reset in mid-run returns every register to zero.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 16; a += 4)
      rd(4'(a), 32'h0, 2'b00);
    chk(32'(tx), 32'h1);
    give_verdict();
  end
endmodule : testbench
